// ---- rsc_top.sv ----
// rsc_top: reset source controller with AHB-Lite register slave
// assumes one 10 MHz clock; hresetn is the power-on reset
//
// Operation
// [RL1] brown-out supervision always on in FAST and SLOW modes
// [RL2] qualified supply in window gives reset and sets the brown-out flag
// [RL3] low supply shorter than the minimum duration is ignored
// [RL4] brown-out reset asserts only after the reset delay time
// [RL5] brown-out supervision off in SLEEP and IDLE
// [RL6] flag bits seven to four and one read as zero
// [RL7] bad pin selection sets bit 3; cleared by software zero or power-on
// [RL8] brown-out flag cleared by writing zero; writing one does nothing
// [RL9] watchdog time-out in normal run resets and sets time-out flag
// [RL10] watchdog time-out in low power clears only program counter and stack
// [RL11] power-on clears time-out and power-down flags; brown-out keeps them
// [RL12] watchdog reset in FAST or SLOW sets time-out, keeps power-down
// [RL13] watchdog reset in IDLE or SLEEP sets both status flags
// [RL14] after reset all interrupt sources are disabled
// [RL15] after reset watchdog counter cleared and counting
// [RL16] after reset all timer modules off
// [RL17] after reset all port pins are inputs
// [RL18] after reset stack at top of stack, program counter zero
// [RL19] bad watchdog enable code sets bit 0; cleared only by software (power-on reset also clears it here)
// [RL20] all resets but the warm one restore control registers
// [RL21] brown-out and watchdog resets keep accumulator and table pointer
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_top (
  input wire logic hclk, // system clock
  input wire logic hresetn, // power-on reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire rsc_pkg::rsc_mode_e run_mode, // current power mode
  input wire logic supply_low, // comparator: supply in window
  input wire logic wdt_timeout, // watchdog overflow pulse
  input wire logic halt_enter, // core enters power down
  input wire logic status_clr, // core clear-watchdog instruction
  input wire logic reset_pin_n, // external reset pin
  output logic brownout_on, // supervision active
  output rsc_pkg::rsc_ctrl_s ctrl, // reset actions for core and peripherals
  output rsc_pkg::rsc_stat_s stat, // time-out and power-down flags
  output logic [7:0] watchdog_control, // watchdog control register
  output logic [7:0] reset_pin_selection // reset pin selection register
);
  import rsc_pkg::*;

  localparam int DLY_CYC = (`RSC_SRESET_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
  localparam int HOLD_CYC = `RSC_HOLD_CYC;

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  logic wr_pend_q;
  logic [1:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic [7:0] flags_q;
  logic [7:0] watchdog_control_q;
  logic [7:0] reset_pin_selection_q;
  logic to_q;
  logic pdf_q;
  rsc_state_e st_q;
  rsc_state_e st_d;
  rsc_kind_e kind_q;
  rsc_kind_e kind_d;
  logic [`RSC_CNT_W-1:0] cnt_q;
  logic [`RSC_CNT_W-1:0] cnt_d;
  rsc_ctrl_s ctrl_q;
  rsc_ctrl_s ctrl_d;

  wire addr_ok = hsel && htrans[1] && hready;
  wire map_hit = (haddr[31:4] == 28'h0);
  wire [1:0] a_idx = haddr[3:2];

  always_comb begin
    rd_mux = 32'h0;
    if (map_hit) begin
      unique case (a_idx)
        `RSC_IDX_FLAGS: rd_mux = {24'h0, flags_q};
        `RSC_IDX_WATCHDOG_CONTROL: rd_mux = {24'h0, watchdog_control_q};
        `RSC_IDX_RESET_PIN_SELECTION: rd_mux = {24'h0, reset_pin_selection_q};
        `RSC_IDX_STAT: rd_mux = {24'h0, run_mode, st_q, brownout_on, pdf_q, to_q};
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 2'h0;
      hrdata_q <= 32'h0;
    end else begin
      wr_pend_q <= addr_ok && hwrite && map_hit;
      wr_idx_q <= a_idx;
      hrdata_q <= (addr_ok && !hwrite) ? rd_mux : 32'h0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  wire [7:0] wd = hwdata[7:0];
  wire wr_flags = wr_pend_q && (wr_idx_q == `RSC_IDX_FLAGS);
  wire wr_watchdog_control = wr_pend_q && (wr_idx_q == `RSC_IDX_WATCHDOG_CONTROL);
  wire wr_reset_pin_selection = wr_pend_q && (wr_idx_q == `RSC_IDX_RESET_PIN_SELECTION);
  wire [4:0] we_code = wd[`RSC_WE_LSB +: 5];
  wire watchdog_control_bad = wr_watchdog_control && (we_code != `RSC_WE_ON_A) && (we_code != `RSC_WE_ON_B);
  wire reset_pin_selection_bad = wr_reset_pin_selection && (wd != `RSC_RESET_PIN_SELECTION_IO) && (wd != `RSC_RESET_PIN_SELECTION_PIN);

  ////////////////////////////////////////////////////////////////////////
  // sources

  logic [2:0] pin_sync_q;
  logic pin_lvl_q;
  logic bo_qual;

  wire pin_lvl_d = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_lvl_q;
  wire pin_req = (reset_pin_selection_q == `RSC_RESET_PIN_SELECTION_PIN) && !pin_lvl_q;
  wire low_pwr = (run_mode == RSC_IDLE) || (run_mode == RSC_SLEEP);

  assign brownout_on = !low_pwr; // see [RL1] [RL5]

  rsc_brownout_qual u_qual (
    .hclk(hclk),
    .hresetn(hresetn),
    .supply_low(supply_low),
    .enable(brownout_on),
    .qualified(bo_qual)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_q <= 3'h7;
      pin_lvl_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], reset_pin_n};
      pin_lvl_q <= pin_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencer

  wire wdt_run = wdt_timeout && (st_q == ST_RUN);

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cnt_d = cnt_q + `RSC_CNT_W'(1);
    unique case (st_q)
      ST_RUN: begin
        cnt_d = '0;
        if (wdt_timeout) begin
          st_d = ST_HOLD;
          kind_d = low_pwr ? K_WARM : K_WDT; // see [RL9] [RL10]
        end else if (pin_req) begin
          st_d = ST_HOLD;
          kind_d = K_PIN;
        end else if (bo_qual) begin
          st_d = ST_WAIT; // see [RL2]
          kind_d = K_BOR;
        end else if (watchdog_control_bad || reset_pin_selection_bad) begin
          st_d = ST_WAIT;
          kind_d = K_CODE;
        end
      end
      ST_WAIT: begin
        if (cnt_q == `RSC_CNT_W'(DLY_CYC - 1)) begin
          st_d = ST_HOLD; // see [RL4]
          cnt_d = '0;
        end
      end
      ST_HOLD: begin
        if (cnt_q == `RSC_CNT_W'(HOLD_CYC - 1)) begin
          st_d = ST_RUN;
          cnt_d = '0;
        end
      end
    endcase
  end

  wire hold_d = (st_d == ST_HOLD);
  wire full_d = hold_d && (kind_d != K_WARM);

  always_comb begin
    ctrl_d = '0;
    ctrl_d.core_rst = full_d;
    ctrl_d.pc_clear = hold_d; // see [RL10] [RL18]
    ctrl_d.sp_top = full_d; // see [RL18]
    ctrl_d.sp_clear = hold_d && (kind_d == K_WARM); // see [RL10]
    ctrl_d.irq_off = full_d; // see [RL14]
    ctrl_d.wdt_clear = full_d; // see [RL15]
    ctrl_d.timers_off = full_d; // see [RL16]
    ctrl_d.ports_in = full_d; // see [RL17]
    ctrl_d.periph_restore = full_d; // see [RL20]
    ctrl_d.acc_keep = hold_d && (kind_d != K_POR) && (kind_d != K_PIN); // see [RL21]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_HOLD;
      kind_q <= K_POR;
      cnt_q <= '0;
      ctrl_q <= '{default: 1'b1, acc_keep: 1'b0, sp_clear: 1'b0};
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;

  ////////////////////////////////////////////////////////////////////////
  // flags and control registers

  wire enter_hold = (st_q != ST_HOLD) && hold_d;
  wire set_to = enter_hold && ((kind_d == K_WDT) || (kind_d == K_WARM));
  wire set_pdf = (enter_hold && (kind_d == K_WARM)) || halt_enter;
  wire set_pinsel = reset_pin_selection_bad;
  wire set_brown = bo_qual && (st_q == ST_RUN);
  wire set_wdcode = watchdog_control_bad;

  logic [7:0] flags_d;

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    flags_d = 8'h0; // see [RL6]
    flags_d[`RSC_F_PINSEL] = set_pinsel ||
      (flags_q[`RSC_F_PINSEL] && !(wr_flags && !wd[`RSC_F_PINSEL])); // see [RL7]
    flags_d[`RSC_F_BROWN] = set_brown ||
      (flags_q[`RSC_F_BROWN] && !(wr_flags && !wd[`RSC_F_BROWN])); // see [RL2] [RL8]
    flags_d[`RSC_F_WDCODE] = set_wdcode ||
      (flags_q[`RSC_F_WDCODE] && !(wr_flags && !wd[`RSC_F_WDCODE])); // see [RL19]
  end

  wire restore = ctrl_q.periph_restore;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 8'h0;
      to_q <= 1'b0; // see [RL11]
      pdf_q <= 1'b0; // see [RL11]
      watchdog_control_q <= `RSC_WATCHDOG_CONTROL_RST;
      reset_pin_selection_q <= `RSC_RESET_PIN_SELECTION_RST;
    end else begin
      flags_q <= flags_d;
      to_q <= set_to || (to_q && !status_clr); // see [RL12] [RL13]
      pdf_q <= set_pdf || (pdf_q && !status_clr); // see [RL12] [RL13]
      watchdog_control_q <= restore ? `RSC_WATCHDOG_CONTROL_RST : (wr_watchdog_control ? wd : watchdog_control_q); // see [RL20]
      reset_pin_selection_q <= restore ? `RSC_RESET_PIN_SELECTION_RST : (wr_reset_pin_selection ? wd : reset_pin_selection_q); // see [RL20]
    end
  end

  assign stat = '{timeout: to_q, powerdown: pdf_q};
  assign watchdog_control = watchdog_control_q;
  assign reset_pin_selection = reset_pin_selection_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  brown_on_run_a: assert property ( // see [RL1]
    (run_mode == RSC_FAST || run_mode == RSC_SLOW) |-> brownout_on)
    else $error("brown-out supervision off in run mode");

  brown_off_low_a: assert property ( // see [RL5]
    low_pwr |-> !brownout_on && !bo_qual)
    else $error("brown-out supervision on in low power");

  brown_flag_set_a: assert property ( // see [RL2]
    (bo_qual && st_q == ST_RUN) |=> flags_q[`RSC_F_BROWN] && st_q == ST_WAIT)
    else $error("qualified brown-out did not flag and wait");

  brown_delay_a: assert property ( // see [RL4]
    (st_q == ST_RUN && st_d == ST_WAIT) |=> (st_q == ST_WAIT) [*8])
    else $error("brown-out reset came before the delay");

  flag_zero_bits_a: assert property ( // see [RL6]
    (addr_ok && !hwrite && map_hit && a_idx == `RSC_IDX_FLAGS)
      |=> hrdata[31:4] == 28'h0 && !hrdata[1])
    else $error("unimplemented flag bits read nonzero");

  pinsel_flag_a: assert property ( // see [RL7]
    reset_pin_selection_bad |=> flags_q[`RSC_F_PINSEL] ##1 flags_q[`RSC_F_PINSEL] || $past(wr_flags))
    else $error("bad pin selection did not set its flag");

  brown_no_sw_set_a: assert property ( // see [RL8]
    $rose(flags_q[`RSC_F_BROWN]) |-> $past(bo_qual))
    else $error("brown-out flag set without brown-out");

  wdt_normal_a: assert property ( // see [RL9] [RL12]
    (wdt_run && !low_pwr) |=> to_q && ctrl.core_rst && pdf_q == $past(pdf_q || halt_enter))
    else $error("watchdog reset in run mode wrong");

  wdt_warm_a: assert property ( // see [RL10] [RL13]
    (wdt_run && low_pwr) |=> to_q && pdf_q && ctrl.pc_clear && ctrl.sp_clear
      && !ctrl.core_rst && !ctrl.periph_restore)
    else $error("warm watchdog reset wrong");

  brown_keeps_stat_a: assert property ( // see [RL11]
    (enter_hold && kind_d == K_BOR && !halt_enter && !status_clr)
      |=> $stable(to_q) && $stable(pdf_q))
    else $error("brown-out reset changed status flags");

  wdcode_flag_a: assert property ( // see [RL19]
    watchdog_control_bad |=> flags_q[`RSC_F_WDCODE])
    else $error("bad watchdog code did not set its flag");

  restore_a: assert property ( // see [RL20]
    ctrl.periph_restore |=> watchdog_control_q == `RSC_WATCHDOG_CONTROL_RST && reset_pin_selection_q == `RSC_RESET_PIN_SELECTION_RST)
    else $error("full reset did not restore control registers");

  acc_keep_a: assert property ( // see [RL21]
    (st_q == ST_HOLD && (kind_q == K_BOR || kind_q == K_WDT)) |-> ctrl.acc_keep)
    else $error("accumulator not kept on brown-out or watchdog reset");

  bor_reset_c: cover property (st_q == ST_WAIT && kind_q == K_BOR ##[1:600] st_q == ST_HOLD);
  warm_reset_c: cover property (wdt_run && low_pwr);
  pin_reset_c: cover property (st_q == ST_RUN && pin_req);
  code_reset_c: cover property (reset_pin_selection_bad ##[1:600] ctrl.core_rst);

endmodule : rsc_top

`default_nettype wire

// ---- rsc_defs.svh ----
// rsc_defs.svh: offsets, fields, reset values and timing of the reset source controller
// assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// register word indexes (byte address = 4 * index)
`define RSC_IDX_FLAGS 2'h0
`define RSC_IDX_WATCHDOG_CONTROL 2'h1
`define RSC_IDX_RESET_PIN_SELECTION 2'h2
`define RSC_IDX_STAT 2'h3

// reset cause flag positions
`define RSC_F_PINSEL 3
`define RSC_F_BROWN 2
`define RSC_F_WDCODE 0

// watchdog enable field and codes
`define RSC_WE_LSB 3
`define RSC_WE_ON_A 5'h0a
`define RSC_WE_ON_B 5'h15
`define RSC_WATCHDOG_CONTROL_RST 8'h53

// reset pin selection codes
`define RSC_RESET_PIN_SELECTION_IO 8'h55
`define RSC_RESET_PIN_SELECTION_PIN 8'haa
`define RSC_RESET_PIN_SELECTION_RST 8'h55

// timing
`define RSC_CLK_NS 100
`define RSC_BOR_MIN_NS 100000
`define RSC_SRESET_NS 50000
`define RSC_HOLD_CYC 4
`define RSC_CNT_W 12

`endif

// ---- rsc_pkg.sv ----
// rsc_pkg: types of the reset source controller
// assumes rsc_defs.svh for all numeric constants
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_FAST = 2'h0,
    RSC_SLOW = 2'h1,
    RSC_IDLE = 2'h2,
    RSC_SLEEP = 2'h3
  } rsc_mode_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_WAIT = 3'h2,
    ST_HOLD = 3'h4
  } rsc_state_e;

  typedef enum logic [5:0] {
    K_POR = 6'h01,
    K_PIN = 6'h02,
    K_BOR = 6'h04,
    K_WDT = 6'h08,
    K_WARM = 6'h10,
    K_CODE = 6'h20
  } rsc_kind_e;

  typedef struct packed {
    logic core_rst;
    logic pc_clear;
    logic sp_top;
    logic sp_clear;
    logic irq_off;
    logic wdt_clear;
    logic timers_off;
    logic ports_in;
    logic periph_restore;
    logic acc_keep;
  } rsc_ctrl_s;

  typedef struct packed {
    logic timeout;
    logic powerdown;
  } rsc_stat_s;

endpackage : rsc_pkg

// ---- rsc_brownout_qual.sv ----
// rsc_brownout_qual: synchronises the supply comparator and qualifies long low episodes
// assumes the comparator output is asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_brownout_qual (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic supply_low, // comparator: supply in brown-out window
  input wire logic enable, // supervision active
  output logic qualified // one-cycle pulse per long episode
);
  import rsc_pkg::*;

  localparam int MIN_CYC = (`RSC_BOR_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;

  logic [2:0] sync_q;
  logic low_q;
  logic [`RSC_CNT_W-1:0] cnt_q;
  logic [`RSC_CNT_W-1:0] cnt_d;
  logic low_d;

  // a change counts once the second and third stages agree
  assign low_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : low_q;

  // count only while low and supervised; saturate one past the limit
  always_comb begin
    cnt_d = cnt_q;
    if (!low_q || !enable) begin
      cnt_d = '0;
    end else if (cnt_q <= `RSC_CNT_W'(MIN_CYC)) begin
      cnt_d = cnt_q + `RSC_CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 3'h0;
      low_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      sync_q <= {sync_q[1:0], supply_low};
      low_q <= low_d;
      cnt_q <= cnt_d;
    end
  end

  // fires only once the episode outlasts the minimum duration
  assign qualified = (cnt_q == `RSC_CNT_W'(MIN_CYC)) && low_q && enable; // see [RL3]

  glitch_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn) // see [RL3]
    qualified |-> $past(low_q) && $past(enable))
    else $error("brown-out qualified without a held low supply");

endmodule : rsc_brownout_qual

`default_nettype wire

// ---- rsc_partner.sv ----
// rsc_partner.sv: behavioural supply comparator, watchdog and core
// assumes the bench calls its tasks; every change follows a rising hclk edge
`timescale 1ns/1ps
`default_nettype none

module rsc_partner (
  input wire logic hclk, // system clock
  output var rsc_pkg::rsc_mode_e run_mode, // core power mode
  output var logic supply_low, // comparator: supply in window
  output var logic reset_pin_n, // external reset pin
  output var logic [2:0] ev // {status_clr, halt_enter, wdt_timeout}
);
  import rsc_pkg::*;

  initial begin
    run_mode = RSC_FAST;
    supply_low = 1'b0;
    reset_pin_n = 1'b1;
    ev = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle event pulses from watchdog and core
  task automatic pulse(input logic [2:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 3'h0;
  endtask : pulse

  task automatic set_mode(input rsc_mode_e m);
    @(posedge hclk);
    run_mode <= m;
  endtask : set_mode

  task automatic set_low(input logic v);
    @(posedge hclk);
    supply_low <= v;
  endtask : set_low

  task automatic set_pin(input logic v);
    @(posedge hclk);
    reset_pin_n <= v;
  endtask : set_pin
endmodule : rsc_partner
`default_nettype wire

// ---- rsc_top_bench.sv ----
// rsc_top_bench.sv: self-checking bench for the reset source controller
// assumes rsc_partner plays comparator, watchdog and core; bench is the bus master
`timescale 1ns/1ps
`default_nettype none

module rsc_top_bench;
  import rsc_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  rsc_mode_e run_mode;
  logic supply_low;
  logic reset_pin_n;
  logic [2:0] ev;
  logic brownout_on;
  rsc_ctrl_s ctrl;
  rsc_stat_s stat;
  logic [7:0] wd_ctl;
  logic [7:0] pin_sel;
  logic [31:0] rd;
  logic [31:0] rdata_s;
  logic ready_s;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  rsc_partner far (.hclk(hclk), .run_mode(run_mode), .supply_low(supply_low),
    .reset_pin_n(reset_pin_n), .ev(ev));

  rsc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .run_mode(run_mode), .supply_low(supply_low), .wdt_timeout(ev[0]),
    .halt_enter(ev[1]), .status_clr(ev[2]), .reset_pin_n(reset_pin_n),
    .brownout_on(brownout_on), .ctrl(ctrl), .stat(stat),
    .watchdog_control(wd_ctl), .reset_pin_selection(pin_sel));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // settled copies of the slave answer, taken mid-cycle so the edge sees the standing value
  always @(negedge hclk) begin
    rdata_s = hrdata;
    ready_s = hreadyout;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic results;
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (ready_s !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (ready_s !== 1'b1) @(posedge hclk);
    rd = rdata_s;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic wait_rst;
    while (ctrl.core_rst !== 1'b1) @(posedge hclk);
  endtask : wait_rst

  task automatic settle;
    @(posedge hclk);
    while (ctrl !== 10'h0) @(posedge hclk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_por;
    @(posedge hclk);
    #1;
    chk(32'(ctrl), 32'h3be);
    chk(32'(stat), 32'h0);
    chk(32'({pin_sel, wd_ctl}), 32'h5553);
    @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    rdc(32'h0, 32'h0);
    rdc(32'h4, 32'h53);
    rdc(32'h8, 32'h55);
    rdc(32'h18, 32'h0);
    wr(32'hfffffff8, 32'hffffff12);
    rdc(32'h8, 32'h55);
  endtask : t_por

  task automatic t_modes;
    far.pulse(3'h4);
    for (int i = 0; i < 4; i++) begin
      far.set_mode(rsc_mode_e'(i));
      @(posedge hclk);
      chk(32'(brownout_on), 32'(i < 2));
      rdc(32'hc, {24'h0, 2'(i), 3'h1, (i < 2), 2'h0});
    end
    far.set_mode(RSC_FAST);
  endtask : t_modes

  task automatic t_wdt;
    wr(32'h4, 32'ha8);
    far.pulse(3'h2);
    far.pulse(3'h1);
    @(negedge hclk);
    chk(32'(ctrl.core_rst), 32'h1);
    chk(32'(stat), 32'h3);
    chk(32'(ctrl.acc_keep), 32'h1);
    settle;
    rdc(32'h4, 32'h53);
    far.pulse(3'h4);
    wr(32'h4, 32'ha8);
    far.set_mode(RSC_SLEEP);
    far.pulse(3'h1);
    @(negedge hclk);
    chk(32'(ctrl), 32'h141);
    chk(32'(stat), 32'h3);
    settle;
    rdc(32'h4, 32'ha8);
    far.set_mode(RSC_FAST);
  endtask : t_wdt

  task automatic t_brown;
    far.set_low(1'b1);
    repeat (400) @(posedge hclk);
    far.set_low(1'b0);
    repeat (1600) @(posedge hclk);
    rdc(32'h0, 32'h0);
    far.set_mode(RSC_SLEEP);
    far.set_low(1'b1);
    repeat (1700) @(posedge hclk);
    far.set_low(1'b0);
    far.set_mode(RSC_FAST);
    rdc(32'h0, 32'h0);
    far.set_low(1'b1);
    repeat (1400) @(posedge hclk);
    chk(32'(ctrl.core_rst), 32'h0);
    wait_rst;
    chk(32'(ctrl.acc_keep), 32'h1);
    chk(32'(stat), 32'h3);
    far.set_low(1'b0);
    settle;
    rdc(32'h0, 32'h4);
    wr(32'h0, 32'hffffffff);
    rdc(32'h0, 32'h4);
    wr(32'h0, 32'h0);
    rdc(32'h0, 32'h0);
  endtask : t_brown

  task automatic t_code;
    wr(32'h8, 32'h12);
    rdc(32'h0, 32'h8);
    wait_rst;
    settle;
    rdc(32'h8, 32'h55);
    rdc(32'h0, 32'h8);
    wr(32'h0, 32'h0);
    wr(32'h4, 32'h0);
    rdc(32'h0, 32'h1);
    wait_rst;
    settle;
    rdc(32'h0, 32'h1);
    wr(32'h0, 32'hfe);
    rdc(32'h0, 32'h0);
  endtask : t_code

  task automatic t_pin;
    wr(32'h8, 32'haa);
    far.set_pin(1'b0);
    wait_rst;
    chk(32'(ctrl.acc_keep), 32'h0);
    far.set_pin(1'b1);
    settle;
    rdc(32'h8, 32'h55);
  endtask : t_pin

  task automatic t_por2;
    wr(32'h8, 32'h33);
    far.pulse(3'h2);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk(32'(stat), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    rdc(32'h0, 32'h0);
  endtask : t_por2

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    t_por;
    t_modes;
    t_wdt;
    t_brown;
    t_code;
    t_pin;
    t_por2;
    results;
  end
endmodule : rsc_top_bench
`default_nettype wire
